// >>> verilog/gcs_pkg.sv
// package for the global configuration and status register group
// assumes one core clock; the serial frame is decoded outside this block
package gcs_pkg;
   localparam int GCS_ADDR_W = 7;
   localparam int GCS_DATA_W = 32;
   // register offsets (write access adds the write flag in bit 7)
   localparam logic [6:0] GCS_OFS_SETTINGS = 7'h00;
   localparam logic [6:0] GCS_OFS_STATUS = 7'h01;
   localparam logic [6:0] GCS_OFS_PROBE = 7'h03;
   localparam logic [6:0] GCS_OFS_READBACK = 7'h04;
   localparam logic [6:0] GCS_OFS_MATCH = 7'h05;
   localparam logic [7:0] GCS_WRITE_FLAG = 8'h80;
   // settings word fields
   localparam int GCS_SET_W = 11;
   localparam int GCS_BIT_MATCH_EN = 3;
   localparam int GCS_BIT_PROBE_EN = 7;
   localparam int GCS_BIT_INV1 = 8;
   localparam int GCS_BIT_INV2 = 9;
   localparam int GCS_BIT_LOCK = 10;
   // status flag fields
   localparam int GCS_STAT_W = 4;
   localparam int GCS_BIT_RESET = 0;
   localparam int GCS_BIT_DRV1 = 1;
   localparam int GCS_BIT_DRV2 = 2;
   localparam int GCS_BIT_PUMP = 3;
   // readback fields and probe select width
   localparam int GCS_BIT_DISABLE_PIN = 7;
   localparam int GCS_VER_LSB = 24;
   localparam int GCS_VER_W = 8;
   localparam int GCS_PROBE_W = 4;
   // reset values
   localparam logic [10:0] GCS_SET_RST = 11'h000;
   localparam logic [3:0] GCS_STAT_RST = 4'h1;
   localparam logic [3:0] GCS_PROBE_RST = 4'h0;
   localparam logic [31:0] GCS_MATCH_RST = 32'h0000_0000;
endpackage

// >>> verilog/gcs_sync.sv
// two-stage synchroniser for asynchronous pin levels
// assumes the caller reads only the second stage
`timescale 1ns/1ps
module gcs_sync #(
   parameter int W = 1
) (
   input wire logic clk_in,
   input wire logic rst_b_in,
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);
   logic [W-1:0] stage1;
   logic [W-1:0] next_stage1;
   logic [W-1:0] next_sync;

   // first stage feeds only the second stage
   always_comb begin
      next_stage1 = async_in;
      next_sync = stage1;
   end

   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         stage1 <= '0;
         sync_out <= '0;
      end else begin
         stage1 <= next_stage1;
         sync_out <= next_sync;
      end
   end
endmodule

// >>> verilog/gcs_regs.sv
// global configuration and status register group of a dual stepper device
// assumes a decoded register port: addr byte (bit7 = write), pulses from
// the serial frame decoder, all on clk_in; pin levels arrive asynchronous
`timescale 1ns/1ps
module gcs_regs
   import gcs_pkg::*;
#(
   parameter logic [7:0] VERSION_CODE = 8'h5a // arbitrary value
) (
   input wire logic clk_in,
   input wire logic rst_b_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic [31:0] reg_wdata_in,
   output logic [31:0] reg_rdata_out,
   input wire logic [31:0] current_position_in,
   input wire logic motor1_dir_in,
   input wire logic motor2_dir_in,
   input wire logic event_request_in,
   input wire logic drv1_fault_in,
   input wire logic drv2_fault_in,
   input wire logic pump_low_in,
   input wire logic drv_disable_pin_in,
   output logic motor1_dir_out,
   output logic motor2_dir_out,
   output logic drivers_enable_out,
   output logic probe_enable_out,
   output logic [3:0] probe_select_out,
   output logic event_request_out,
   output logic event_request_oe_out,
   output logic position_pulse_output_out,
   output logic position_pulse_output_oe_out
);
   logic [GCS_SET_W-1:0] global_settings;
   logic [GCS_SET_W-1:0] next_global_settings;
   logic [GCS_STAT_W-1:0] global_status_flags;
   logic [GCS_STAT_W-1:0] next_global_status_flags;
   logic [GCS_PROBE_W-1:0] probe_signal_select;
   logic [GCS_PROBE_W-1:0] next_probe_signal_select;
   logic [31:0] position_match_value;
   logic [31:0] next_position_match_value;
   logic [31:0] next_rdata;
   logic [2:0] pin_sync;
   logic drv1_fault;
   logic drv2_fault;
   logic pump_low;
   logic disable_pin;
   logic next_m1, next_m2, next_en, next_pulse, next_evt;
   logic is_wr, is_rd, stat_rd;
   logic [6:0] ofs;

   // fault levels come from the analog side, so synchronise them
   gcs_sync #(.W(3)) u_fault_sync (
      .clk_in(clk_in),
      .rst_b_in(rst_b_in),
      .async_in({drv1_fault_in, drv2_fault_in, pump_low_in}),
      .sync_out(pin_sync)
   );
   gcs_sync #(.W(1)) u_pin_sync (
      .clk_in(clk_in),
      .rst_b_in(rst_b_in),
      .async_in(drv_disable_pin_in),
      .sync_out(disable_pin)
   );
   assign drv1_fault = pin_sync[2];
   assign drv2_fault = pin_sync[1];
   assign pump_low = pin_sync[0];

   // address decode: bit 7 marks a write
   assign ofs = reg_addr_in[6:0];
   assign is_wr = reg_wr_in && ((reg_addr_in & GCS_WRITE_FLAG) != 8'h00);
   assign is_rd = reg_rd_in && ((reg_addr_in & GCS_WRITE_FLAG) == 8'h00);
   assign stat_rd = is_rd && (ofs == GCS_OFS_STATUS);

   // writable registers; settings freeze once the lock bit is set
   always_comb begin
      next_global_settings = global_settings;
      next_probe_signal_select = probe_signal_select;
      next_position_match_value = position_match_value;
      if (is_wr && ofs == GCS_OFS_SETTINGS &&
          !global_settings[GCS_BIT_LOCK]) begin
         next_global_settings = reg_wdata_in[GCS_SET_W-1:0];
      end
      if (is_wr && ofs == GCS_OFS_PROBE) begin
         next_probe_signal_select = reg_wdata_in[GCS_PROBE_W-1:0];
      end
      if (is_wr && ofs == GCS_OFS_MATCH) begin
         next_position_match_value = reg_wdata_in;
      end
   end

   // status flags: a read clears, but a live fault sets again (set wins)
   always_comb begin
      next_global_status_flags = global_status_flags;
      if (stat_rd) begin
         next_global_status_flags = '0;
      end
      if (drv1_fault) begin
         next_global_status_flags[GCS_BIT_DRV1] = 1'b1;
      end
      if (drv2_fault) begin
         next_global_status_flags[GCS_BIT_DRV2] = 1'b1;
      end
      if (pump_low) begin
         next_global_status_flags[GCS_BIT_PUMP] = 1'b1;
      end
   end

   // read mux; write-only registers read as zero
   always_comb begin
      next_rdata = reg_rdata_out;
      if (is_rd) begin
         next_rdata = 32'h0000_0000;
         unique case (ofs)
            GCS_OFS_SETTINGS: next_rdata[GCS_SET_W-1:0] = global_settings;
            GCS_OFS_STATUS: next_rdata[GCS_STAT_W-1:0] = global_status_flags;
            GCS_OFS_READBACK: begin
               next_rdata[GCS_BIT_DISABLE_PIN] = disable_pin;
               next_rdata[GCS_VER_LSB +: GCS_VER_W] = VERSION_CODE;
            end
            default: next_rdata = 32'h0000_0000;
         endcase
      end
   end

   // outputs toward the core, one register stage each
   always_comb begin
      next_m1 = motor1_dir_in ^ global_settings[GCS_BIT_INV1];
      next_m2 = motor2_dir_in ^ global_settings[GCS_BIT_INV2];
      next_en = !pump_low;
      next_pulse = (current_position_in == position_match_value);
      next_evt = event_request_in;
   end

   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         global_settings <= GCS_SET_RST;
         global_status_flags <= GCS_STAT_RST;
         probe_signal_select <= GCS_PROBE_RST;
         position_match_value <= GCS_MATCH_RST;
         reg_rdata_out <= 32'h0000_0000;
         motor1_dir_out <= 1'b0;
         motor2_dir_out <= 1'b0;
         drivers_enable_out <= 1'b0;
         probe_enable_out <= 1'b0;
         probe_select_out <= 4'h0;
         event_request_out <= 1'b0;
         event_request_oe_out <= 1'b0;
         position_pulse_output_out <= 1'b0;
         position_pulse_output_oe_out <= 1'b0;
      end else begin
         global_settings <= next_global_settings;
         global_status_flags <= next_global_status_flags;
         probe_signal_select <= next_probe_signal_select;
         position_match_value <= next_position_match_value;
         reg_rdata_out <= next_rdata;
         motor1_dir_out <= next_m1;
         motor2_dir_out <= next_m2;
         drivers_enable_out <= next_en;
         // probe routing follows the settings bit; select rides with it
         probe_enable_out <= next_global_settings[GCS_BIT_PROBE_EN];
         probe_select_out <= next_probe_signal_select;
         event_request_out <= next_evt;
         // both pins float unless match outputs are enabled
         event_request_oe_out <= next_global_settings[GCS_BIT_MATCH_EN];
         position_pulse_output_out <= next_pulse;
         position_pulse_output_oe_out <=
            next_global_settings[GCS_BIT_MATCH_EN];
      end
   end

   // assertions
   property p_lock_holds;
      @(posedge clk_in) disable iff (!rst_b_in)
      global_settings[GCS_BIT_LOCK] |=> $stable(global_settings);
   endproperty
   a_lock_holds: assert property (p_lock_holds)
      else $error("locked settings changed");

   property p_lock_sticky;
      @(posedge clk_in) disable iff (!rst_b_in)
      global_settings[GCS_BIT_LOCK] |=> global_settings[GCS_BIT_LOCK];
   endproperty
   a_lock_sticky: assert property (p_lock_sticky)
      else $error("lock dropped without reset");

   property p_oe_follows;
      @(posedge clk_in) disable iff (!rst_b_in)
      1'b1 |=> (position_pulse_output_oe_out ==
                global_settings[GCS_BIT_MATCH_EN]) &&
               (event_request_oe_out == position_pulse_output_oe_out);
   endproperty
   a_oe_follows: assert property (p_oe_follows)
      else $error("output enables disagree with settings");

   property p_probe;
      @(posedge clk_in) disable iff (!rst_b_in)
      1'b1 |=> probe_enable_out == global_settings[GCS_BIT_PROBE_EN];
   endproperty
   a_probe: assert property (p_probe)
      else $error("probe enable wrong");

   property p_probe_sel;
      @(posedge clk_in) disable iff (!rst_b_in)
      (is_wr && ofs == GCS_OFS_PROBE) |=>
         probe_select_out == $past(reg_wdata_in[3:0]);
   endproperty
   a_probe_sel: assert property (p_probe_sel)
      else $error("probe select not taken");

   property p_inv1;
      @(posedge clk_in) disable iff (!rst_b_in)
      1'b1 |=> motor1_dir_out ==
         ($past(motor1_dir_in) ^ $past(global_settings[GCS_BIT_INV1]));
   endproperty
   a_inv1: assert property (p_inv1)
      else $error("motor 1 direction wrong");

   property p_inv2;
      @(posedge clk_in) disable iff (!rst_b_in)
      1'b1 |=> motor2_dir_out ==
         ($past(motor2_dir_in) ^ $past(global_settings[GCS_BIT_INV2]));
   endproperty
   a_inv2: assert property (p_inv2)
      else $error("motor 2 direction wrong");

   property p_stat_clear;
      @(posedge clk_in) disable iff (!rst_b_in)
      stat_rd && !drv1_fault |=> !global_status_flags[GCS_BIT_RESET] &&
                                 !global_status_flags[GCS_BIT_DRV1];
   endproperty
   a_stat_clear: assert property (p_stat_clear)
      else $error("status read did not clear");

   property p_drv1;
      @(posedge clk_in) disable iff (!rst_b_in)
      drv1_fault |=> global_status_flags[GCS_BIT_DRV1];
   endproperty
   a_drv1: assert property (p_drv1)
      else $error("driver 1 flag not latched");

   property p_drv2;
      @(posedge clk_in) disable iff (!rst_b_in)
      drv2_fault |=> global_status_flags[GCS_BIT_DRV2];
   endproperty
   a_drv2: assert property (p_drv2)
      else $error("driver 2 flag not latched");

   property p_pump;
      @(posedge clk_in) disable iff (!rst_b_in)
      pump_low |=> !drivers_enable_out && global_status_flags[GCS_BIT_PUMP];
   endproperty
   a_pump: assert property (p_pump)
      else $error("drivers enabled during undervoltage");

   property p_version;
      @(posedge clk_in) disable iff (!rst_b_in)
      (is_rd && ofs == GCS_OFS_READBACK) |=>
         reg_rdata_out[GCS_VER_LSB +: GCS_VER_W] == VERSION_CODE &&
         reg_rdata_out[GCS_BIT_DISABLE_PIN] == $past(disable_pin);
   endproperty
   a_version: assert property (p_version)
      else $error("readback wrong");

   property p_pulse;
      @(posedge clk_in) disable iff (!rst_b_in)
      (current_position_in == position_match_value) |=>
         position_pulse_output_out;
   endproperty
   a_pulse: assert property (p_pulse)
      else $error("pulse missing on match");

   // the pulse must also drop, not only rise
   property p_pulse_low;
      @(posedge clk_in) disable iff (!rst_b_in)
      (current_position_in != position_match_value) |=>
         !position_pulse_output_out;
   endproperty
   a_pulse_low: assert property (p_pulse_low)
      else $error("pulse stays high on mismatch");

   property p_reset_val;
      @(posedge clk_in)
      !rst_b_in |=> global_settings == GCS_SET_RST &&
                    position_match_value == GCS_MATCH_RST;
   endproperty
   a_reset_val: assert property (p_reset_val)
      else $error("reset values wrong");

   c_lock: cover property (@(posedge clk_in) disable iff (!rst_b_in)
      global_settings[GCS_BIT_LOCK] && is_wr && ofs == GCS_OFS_SETTINGS);
   c_stat_read: cover property (@(posedge clk_in) disable iff (!rst_b_in)
      stat_rd && global_status_flags[GCS_BIT_DRV1]);
   c_pulse: cover property (@(posedge clk_in) disable iff (!rst_b_in)
      position_pulse_output_out && position_pulse_output_oe_out);
endmodule

// >>> sim/gcs_host_model.sv
// host model driving the decoded register port of the config block
// assumes the bench calls its tasks; signals change at the falling edge
`timescale 1ns/1ps
module gcs_host_model
   import gcs_pkg::*;
(
   input wire logic clk_in,
   output logic reg_wr_out,
   output logic reg_rd_out,
   output logic [7:0] reg_addr_out,
   output logic [31:0] reg_wdata_out,
   input wire logic [31:0] reg_rdata_in
);
   initial begin
      reg_wr_out = 1'b0;
      reg_rd_out = 1'b0;
      reg_addr_out = 8'h00;
      reg_wdata_out = 32'h0000_0000;
   end
   // idle bus shows the inverse of the last value, so stale data never helps
   task automatic release_bus();
      reg_wr_out = 1'b0;
      reg_rd_out = 1'b0;
      reg_addr_out = ~reg_addr_out;
      reg_wdata_out = ~reg_wdata_out;
   endtask
   // one write cycle, held across exactly one rising edge
   task automatic write_reg(input logic [6:0] ofs, input logic [31:0] data);
      @(negedge clk_in);
      reg_addr_out = GCS_WRITE_FLAG | {1'b0, ofs};
      reg_wdata_out = data;
      reg_wr_out = 1'b1;
      @(negedge clk_in);
      release_bus();
   endtask
   // a write strobe lacking the write flag; the block must ignore it
   task automatic write_noflag(input logic [6:0] ofs,
                               input logic [31:0] data);
      @(negedge clk_in);
      reg_addr_out = {1'b0, ofs};
      reg_wdata_out = data;
      reg_wr_out = 1'b1;
      @(negedge clk_in);
      release_bus();
   endtask
   // one read cycle; data is taken once the taking edge has landed
   task automatic read_reg(input logic [6:0] ofs, output logic [31:0] data);
      @(negedge clk_in);
      reg_addr_out = {1'b0, ofs};
      reg_rd_out = 1'b1;
      @(negedge clk_in);
      data = reg_rdata_in;
      release_bus();
   endtask
endmodule

// >>> sim/tb_top.sv
// self-checking bench for the global configuration and status registers
// assumes the host model drives the register port; 25 MHz core clock
`timescale 1ns/1ps
module tb_top
   import gcs_pkg::*;
();
   localparam logic [7:0] VER = 8'h3c; // arbitrary value
   logic clk = 1'b0, rst_b = 1'b0, wr, rd, dir1 = 1'b0, dir2 = 1'b0;
   logic evt = 1'b0, f1 = 1'b0, f2 = 1'b0, pump = 1'b0, dis_pin = 1'b0;
   logic [7:0] addr;
   logic [31:0] wdata, rdata, pos = 32'h0;
   logic m1_dir, m2_dir, drv_en, probe_en, ev_out, ev_oe, pp_out, pp_oe;
   logic [3:0] probe_sel;
   int errors = 0, checked = 0, cycles = 0;
   // 40 ns period
   always #20 clk = ~clk;
   gcs_host_model host_i (.clk_in(clk), .reg_wr_out(wr), .reg_rd_out(rd),
      .reg_addr_out(addr), .reg_wdata_out(wdata), .reg_rdata_in(rdata));
   gcs_regs #(.VERSION_CODE(VER)) gcs_regs_i (.clk_in(clk), .rst_b_in(rst_b),
      .reg_wr_in(wr), .reg_rd_in(rd), .reg_addr_in(addr),
      .reg_wdata_in(wdata), .reg_rdata_out(rdata),
      .current_position_in(pos), .motor1_dir_in(dir1),
      .motor2_dir_in(dir2), .event_request_in(evt), .drv1_fault_in(f1),
      .drv2_fault_in(f2), .pump_low_in(pump), .drv_disable_pin_in(dis_pin),
      .motor1_dir_out(m1_dir), .motor2_dir_out(m2_dir),
      .drivers_enable_out(drv_en), .probe_enable_out(probe_en),
      .probe_select_out(probe_sel), .event_request_out(ev_out),
      .event_request_oe_out(ev_oe), .position_pulse_output_out(pp_out),
      .position_pulse_output_oe_out(pp_oe));
   task automatic end_of_test();
      if (errors == 0 && checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic chk_word(input string what, input logic [31:0] exp,
                           input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic chk_bit(input string what, input logic exp, input logic got);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("BAD %s expected %b seen %b", what, exp, got);
      end
   endtask
   function automatic logic exp_dir(input logic cmd, input logic inv);
      return cmd ^ inv;
   endfunction
   // only bit 7 and the top byte carry meaning; the rest is masked away
   function automatic logic [31:0] exp_readback(input logic pin);
      return {VER, 16'h0000, pin, 7'h00};
   endfunction
   task automatic do_reset();
      @(negedge clk);
      rst_b = 1'b0;
      repeat (20) @(negedge clk);
      rst_b = 1'b1;
   endtask
   // hang guard, well above the few hundred cycles the run needs
   always @(posedge clk) begin
      cycles++;
      if (cycles == 30000) begin
         errors++;
         end_of_test();
      end
   end
   initial begin
      logic [31:0] d, v;
      logic [6:0] zero_ofs [4];
      int i;
      zero_ofs = '{7'h02, GCS_OFS_PROBE, GCS_OFS_MATCH, 7'h7f};
      v = $urandom(32'hcc6d);
      do_reset();
      chk_bit("pulse oe", 1'b0, pp_oe);
      chk_bit("event oe", 1'b0, ev_oe);
      host_i.read_reg(GCS_OFS_STATUS, d);
      chk_word("status", 32'h0000_0001, d);
      host_i.read_reg(GCS_OFS_STATUS, d);
      chk_word("status", 32'h0000_0000, d);
      host_i.read_reg(GCS_OFS_SETTINGS, d);
      chk_word("settings", 32'h0000_0000, d);
      // pin level and version, both pin levels twice
      for (i = 0; i < 4; i++) begin
         dis_pin = i[0];
         repeat (4) @(negedge clk);
         host_i.read_reg(GCS_OFS_READBACK, d);
         chk_word("readback", exp_readback(i[0]), d & 32'hff00_0080);
      end
      // random settings with all-set and all-clear corners
      for (i = 0; i < 12; i++) begin
         v = $urandom & 32'h0000_0388;
         if (i == 0) v = 32'h0000_0388;
         if (i == 1) v = 32'h0000_0000;
         host_i.write_reg(GCS_OFS_SETTINGS, v);
         {dir1, dir2, evt} = 3'($urandom);
         repeat (2) @(negedge clk);
         chk_bit("motor1 dir", exp_dir(dir1, v[8]), m1_dir);
         chk_bit("motor2 dir", exp_dir(dir2, v[9]), m2_dir);
         chk_bit("probe enable", v[7], probe_en);
         chk_bit("pulse oe", v[3], pp_oe);
         chk_bit("event oe", v[3], ev_oe);
         chk_bit("event out", evt, ev_out);
         host_i.read_reg(GCS_OFS_SETTINGS, d);
         chk_word("settings", v, d);
      end
      // every probe select code
      for (i = 0; i < 16; i++) begin
         host_i.write_reg(GCS_OFS_PROBE, 32'(i));
         @(negedge clk);
         chk_word("probe select", 32'(i), {28'h0, probe_sel});
      end
      host_i.write_reg(GCS_OFS_PROBE, 32'h0000_0000);
      // position match, including the all-ones and top-bit corners
      host_i.write_reg(GCS_OFS_SETTINGS, 32'h0000_0008);
      for (i = 0; i < 6; i++) begin
         v = (i == 0) ? 32'hffff_ffff : $urandom;
         host_i.write_reg(GCS_OFS_MATCH, v);
         pos = v;
         repeat (3) @(negedge clk);
         chk_bit("pulse equal", 1'b1, pp_out);
         pos = i[0] ? v ^ 32'h8000_0000 : v + 32'h1;
         repeat (3) @(negedge clk);
         chk_bit("pulse differ", 1'b0, pp_out);
      end
      // write-only and unmapped places read zero
      for (i = 0; i < 4; i++) begin
         host_i.read_reg(zero_ofs[i], d);
         chk_word("empty read", 32'h0000_0000, d);
      end
      // each fault: live flag survives reads, latched flag holds after it goes and clears on the next read
      for (i = 0; i < 3; i++) begin
         f1 = (i == 0);
         f2 = (i == 1);
         pump = (i == 2);
         repeat (5) @(negedge clk);
         v = 32'h1 << (i + 1);
         chk_bit("drivers enable", i != 2, drv_en);
         host_i.read_reg(GCS_OFS_STATUS, d);
         chk_word("status fault", v, d);
         host_i.read_reg(GCS_OFS_STATUS, d);
         chk_word("status live", v, d);
         {f1, f2, pump} = 3'b000;
         repeat (5) @(negedge clk);
         chk_bit("drivers enable", 1'b1, drv_en);
         host_i.read_reg(GCS_OFS_STATUS, d);
         chk_word("status latched", v, d);
         host_i.read_reg(GCS_OFS_STATUS, d);
         chk_word("status cleared", 32'h0000_0000, d);
      end
      // lock, a refused write, then a reset that lifts the lock
      v = 32'h0000_0400 | ($urandom & 32'h0000_0308);
      host_i.write_reg(GCS_OFS_SETTINGS, v);
      host_i.write_reg(GCS_OFS_SETTINGS, 32'h0000_0080);
      host_i.read_reg(GCS_OFS_SETTINGS, d);
      chk_word("locked settings", v, d);
      chk_bit("probe enable", 1'b0, probe_en);
      do_reset();
      host_i.read_reg(GCS_OFS_SETTINGS, d);
      chk_word("settings", 32'h0000_0000, d);
      host_i.write_reg(GCS_OFS_SETTINGS, 32'h0000_0088);
      host_i.read_reg(GCS_OFS_SETTINGS, d);
      chk_word("settings", 32'h0000_0088, d);
      host_i.write_noflag(GCS_OFS_SETTINGS, 32'h0000_0300);
      host_i.read_reg(GCS_OFS_SETTINGS, d);
      chk_word("unflagged write", 32'h0000_0088, d);
      host_i.read_reg(GCS_OFS_STATUS, d);
      chk_word("status", 32'h0000_0001, d);
      end_of_test();
   end
endmodule
